// *** verilog/scrc_pkg.sv ***
// Purpose: Constants and types for the seconds counter with power control.
// Assumes: System clock of 10 MHz; oscillator clock near 32768 Hz.
// Notes: Long delays are turned into cycle counts by the top module.
package scrc_pkg;

  localparam int unsigned CLK_KHZ          = 10000;
  localparam int unsigned RELEASE_DELAY_MS = 250;
  localparam int unsigned OSC_STARTUP_MS   = 1000;
  localparam int unsigned OSC_DIV          = 32768;
  localparam logic [14:0] PRESC_LAST       = 15'(OSC_DIV - 1);

  // The value is arbitrary.
  localparam logic [6:0]  SLAVE_ADDR  = 7'h2a;

  localparam logic [2:0]  REG_CNT0    = 3'h0;
  localparam logic [2:0]  REG_CNT3    = 3'h3;
  localparam logic [2:0]  REG_CTRL    = 3'h4;
  localparam logic [2:0]  REG_TRICKLE = 3'h5;
  localparam logic [2:0]  REG_LAST    = 3'h5;

  localparam int unsigned CTRL_DIS_BIT = 7;
  localparam int unsigned KEY_LSB      = 4;
  localparam int unsigned DIODE_LSB    = 2;
  localparam int unsigned RES_LSB      = 0;
  localparam logic [3:0]  CHARGE_KEY   = 4'ha;
  localparam logic [1:0]  DIODE_NONE   = 2'h1;
  localparam logic [1:0]  DIODE_ONE    = 2'h2;
  localparam logic [1:0]  RES_OFF      = 2'h0;
  localparam logic [7:0]  TRICKLE_RST  = 8'h00;
  localparam logic        CTRL_DIS_RST = 1'b0;

  typedef enum logic [1:0] {
    PF_DOWN = 2'h0,
    PF_HOLD = 2'h1,
    PF_UP   = 2'h2
  } scrc_pf_e;

  typedef enum logic [2:0] {
    L_IDLE = 3'h0,
    L_RX   = 3'h1,
    L_ACK1 = 3'h2,
    L_ACK2 = 3'h3,
    L_TX   = 3'h4,
    L_TXA1 = 3'h5,
    L_TXA2 = 3'h6,
    L_LOAD = 3'h7
  } scrc_lnk_e;

  typedef struct packed {
    logic       wr;
    logic [2:0] addr;
    logic [7:0] data;
  } scrc_req_s;

  typedef struct packed {
    logic       en;
    logic       diode;
    logic [1:0] res;
  } scrc_chg_s;

endpackage : scrc_pkg

// *** verilog/scrc_top.sv ***
// Purpose: Seconds counter, power-fail reset, oscillator and trickle
//   control, reached through a two-wire serial slave.
// Assumes: vcc_ok and on_backup come from analog comparators; osc_in is
//   the oscillator square wave; scl and sda are sampled on link_clk.
// Notes: The counter bytes are read one by one without a snapshot.
//
// Overview of operation
// - Serial access only while supply is good.
// - Supply low blocks every register access.
// - Backup keeps oscillator and counter running.
// - Control bit 7 disables oscillator on backup.
// - Disable bit on backup halts oscillator, standby.
// - Main power: oscillator runs, counts if bit clear.
// - Supply fail drives reset and blocks access.
// - Reset held for release delay after recovery.
// - Stopped oscillator adds start-up time to hold.
// - Only key 1010 in bits 7:4 enables charging.
// - Trickle register resets to zero, charger off.
// - Diode field: 01 none, 10 one, else off.
// - Resistor field picks 250, 2k, 4k; 00 off.
// - Slave only, standard and fast bus rates.
// - SDA changes only while SCL is low.
// - SDA fall is START, rise is STOP.
// - Idle when both high; one pulse per bit.
// - Bytes plus acknowledge, any count per transfer.
// - Counter at 0..3 LSB first, control 4, trickle 5.
// - Pointer advances per byte, wraps 5 to 0.
// - Address byte matched and acked; write loads pointer.
// - Read starts at pointer, ends on not-acknowledge.
module scrc_top #(
  parameter int unsigned RELEASE_CYC =
    scrc_pkg::RELEASE_DELAY_MS * scrc_pkg::CLK_KHZ,
  parameter int unsigned STARTUP_CYC =
    scrc_pkg::OSC_STARTUP_MS * scrc_pkg::CLK_KHZ
) (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                link_clk,
  input  wire logic                vcc_ok,
  input  wire logic                on_backup,
  input  wire logic                osc_in,
  input  wire logic                scl_i,
  input  wire logic                sda_i,
  output      logic                sda_o,
  output      logic                sda_oe,
  input  wire logic                reset_n_i,
  output      logic                reset_n_o,
  output      logic                reset_oe,
  output      logic                osc_enable,
  output      logic                standby,
  output      scrc_pkg::scrc_chg_s charge
);
  import scrc_pkg::*;

  typedef struct packed {
    logic       req_s1;
    logic       req_s2;
    logic       req_s3;
    logic       vok_s1;
    logic       vok_s2;
    logic       bk_s1;
    logic       bk_s2;
    logic       osc_s1;
    logic       osc_s2;
    logic       osc_s3;
    logic [14:0] presc;
    logic [31:0] count;
    logic       ctrl_dis;
    logic [7:0] trickle;
    logic [7:0] rdata;
    logic       ack_tgl;
    scrc_pf_e   pf;
    logic [31:0] hold;
    logic       was_off;
    logic       rst_oe;
    logic       osc_en;
    logic       standby;
    scrc_chg_s  chg;
  } scrc_sys_s;

  typedef struct packed {
    logic       scl_s1;
    logic       scl_s2;
    logic       scl_s3;
    logic       sda_s1;
    logic       sda_s2;
    logic       sda_s3;
    logic       vok_s1;
    logic       vok_s2;
    logic       ack_s1;
    logic       ack_s2;
    scrc_lnk_e  st;
    logic [2:0] bitc;
    logic [7:0] sh;
    logic       rd;
    logic [1:0] kind;
    logic [2:0] ptr;
    logic       req_tgl;
    scrc_req_s  req;
    logic       sda_oe;
  } scrc_lnk_s;

  localparam scrc_sys_s SYS_RST = '{pf: PF_DOWN, rst_oe: 1'b1,
    osc_en: 1'b1, trickle: TRICKLE_RST, ctrl_dis: CTRL_DIS_RST,
    default: '0};

  scrc_sys_s  s_q;
  scrc_sys_s  s_d;
  scrc_lnk_s  l_q;
  scrc_lnk_s  l_d;
  logic       s_req;
  logic       s_tick;
  logic       s_cnt_wr;
  logic [7:0] key_byte;
  logic       l_start;
  logic       l_stop;
  logic       l_rise;
  logic       l_fall;
  logic [7:0] l_byte;
  logic       l_ack_ok;
  logic [2:0] l_nxt;

  // System side: power supervision, counter and register file.
  assign s_req  = s_q.req_s2 ^ s_q.req_s3;
  assign s_tick = s_q.osc_s2 & ~s_q.osc_s3 & (s_q.presc == PRESC_LAST);
  assign s_cnt_wr = s_req & s_q.vok_s2 & l_q.req.wr
                  & (l_q.req.addr <= REG_CNT3);
  assign key_byte = s_q.trickle;

  always_comb begin
    s_d = s_q;
    s_d.req_s1 = l_q.req_tgl;
    s_d.req_s2 = s_q.req_s1;
    s_d.req_s3 = s_q.req_s2;
    s_d.vok_s1 = vcc_ok;
    s_d.vok_s2 = s_q.vok_s1;
    s_d.bk_s1  = on_backup;
    s_d.bk_s2  = s_q.bk_s1;
    s_d.osc_s1 = osc_in;
    s_d.osc_s2 = s_q.osc_s1;
    s_d.osc_s3 = s_q.osc_s2;
    // Counting goes on whatever the supply, so backup keeps time.
    if (s_q.osc_s2 & ~s_q.osc_s3) begin
      s_d.presc = s_q.presc + 15'h0001;
    end
    if (s_tick && !s_q.ctrl_dis) begin
      s_d.count = s_q.count + 32'h1;
    end
    // The request fields are stable while the toggle is in flight.
    if (s_req) begin
      s_d.ack_tgl = ~s_q.ack_tgl;
      if (s_q.vok_s2) begin
        if (l_q.req.wr) begin
          if (l_q.req.addr <= REG_CNT3) begin
            s_d.count[{l_q.req.addr[1:0], 3'b000} +: 8] =
              l_q.req.data;
          end else if (l_q.req.addr == REG_CTRL) begin
            s_d.ctrl_dis = l_q.req.data[CTRL_DIS_BIT];
          end else if (l_q.req.addr == REG_TRICKLE) begin
            s_d.trickle = l_q.req.data;
          end
        end else begin
          if (l_q.req.addr <= REG_CNT3) begin
            s_d.rdata = s_q.count[{l_q.req.addr[1:0], 3'b000} +: 8];
          end else if (l_q.req.addr == REG_CTRL) begin
            s_d.rdata = {s_q.ctrl_dis, 7'h00};
          end else if (l_q.req.addr == REG_TRICKLE) begin
            s_d.rdata = s_q.trickle;
          end else begin
            s_d.rdata = 8'h00;
          end
        end
      end
    end
    s_d.osc_en  = ~(s_q.bk_s2 & s_q.ctrl_dis);
    s_d.standby = s_q.bk_s2 & s_q.ctrl_dis;
    s_d.chg.en  = (key_byte[KEY_LSB +: 4] == CHARGE_KEY)
                & ((key_byte[DIODE_LSB +: 2] == DIODE_NONE)
                 | (key_byte[DIODE_LSB +: 2] == DIODE_ONE))
                & (key_byte[RES_LSB +: 2] != RES_OFF);
    s_d.chg.diode = s_d.chg.en & (key_byte[DIODE_LSB +: 2] == DIODE_ONE);
    s_d.chg.res   = s_d.chg.en ? key_byte[RES_LSB +: 2] : RES_OFF;
    unique case (s_q.pf)
      PF_DOWN: begin
        if (s_q.bk_s2 && s_q.ctrl_dis) begin
          s_d.was_off = 1'b1;
        end
        if (s_q.vok_s2) begin
          s_d.pf   = PF_HOLD;
          s_d.hold = (s_q.was_off || (s_q.bk_s2 && s_q.ctrl_dis))
                   ? 32'(RELEASE_CYC + STARTUP_CYC)
                   : 32'(RELEASE_CYC);
        end
      end
      PF_HOLD: begin
        if (!s_q.vok_s2) begin
          s_d.pf = PF_DOWN;
        end else if (s_q.hold <= 32'h1) begin
          s_d.pf      = PF_UP;
          s_d.was_off = 1'b0;
        end else begin
          s_d.hold = s_q.hold - 32'h1;
        end
      end
      PF_UP: begin
        if (!s_q.vok_s2) begin
          s_d.pf = PF_DOWN;
        end
      end
      default: begin
        s_d.pf = PF_DOWN;
      end
    endcase
    s_d.rst_oe = (s_d.pf != PF_UP);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= SYS_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Link side: serial slave oversampling the bus pins.
  assign l_start = l_q.scl_s2 & l_q.scl_s3 & l_q.sda_s3 & ~l_q.sda_s2;
  assign l_stop  = l_q.scl_s2 & l_q.scl_s3 & ~l_q.sda_s3 & l_q.sda_s2;
  assign l_rise  = l_q.scl_s2 & ~l_q.scl_s3;
  assign l_fall  = ~l_q.scl_s2 & l_q.scl_s3;
  assign l_byte  = {l_q.sh[6:0], l_q.sda_s2};
  assign l_ack_ok = (l_q.ack_s2 == l_q.req_tgl);
  assign l_nxt   = (l_q.ptr == REG_LAST) ? REG_CNT0
                 : l_q.ptr + 3'h1;

  always_comb begin
    l_d = l_q;
    l_d.scl_s1 = scl_i;
    l_d.scl_s2 = l_q.scl_s1;
    l_d.scl_s3 = l_q.scl_s2;
    l_d.sda_s1 = sda_i;
    l_d.sda_s2 = l_q.sda_s1;
    l_d.sda_s3 = l_q.sda_s2;
    l_d.vok_s1 = vcc_ok;
    l_d.vok_s2 = l_q.vok_s1;
    l_d.ack_s1 = s_q.ack_tgl;
    l_d.ack_s2 = l_q.ack_s1;
    if (!l_q.vok_s2 || l_stop) begin
      l_d.st     = L_IDLE;
      l_d.sda_oe = 1'b0;
    end else if (l_start) begin
      l_d.st     = L_RX;
      l_d.kind   = 2'h0;
      l_d.bitc   = 3'h0;
      l_d.rd     = 1'b0;
      l_d.sda_oe = 1'b0;
    end else begin
      unique case (l_q.st)
        L_IDLE: begin
          l_d.sda_oe = 1'b0;
        end
        L_RX: begin
          if (l_rise) begin
            l_d.sh   = l_byte;
            l_d.bitc = l_q.bitc + 3'h1;
            if (l_q.bitc == 3'h7) begin
              l_d.st = L_ACK1;
              unique case (l_q.kind)
                2'h0: begin
                  if (l_byte[7:1] == SLAVE_ADDR) begin
                    l_d.rd = l_byte[0];
                    if (l_byte[0]) begin
                      l_d.req_tgl = ~l_q.req_tgl;
                      l_d.req     = '{wr: 1'b0, addr: l_q.ptr,
                                      data: 8'h00};
                    end
                  end else begin
                    l_d.st = L_IDLE;
                  end
                end
                2'h1: begin
                  l_d.ptr = (l_byte > {5'h00, REG_LAST}) ? REG_CNT0
                          : l_byte[2:0];
                end
                default: begin
                  l_d.req_tgl = ~l_q.req_tgl;
                  l_d.req     = '{wr: 1'b1, addr: l_q.ptr,
                                  data: l_byte};
                  l_d.ptr     = l_nxt;
                end
              endcase
            end
          end
        end
        L_ACK1: begin
          if (l_fall) begin
            l_d.sda_oe = 1'b1;
            l_d.st     = L_ACK2;
          end
        end
        L_ACK2, L_LOAD: begin
          if (l_fall) begin
            if (l_q.st == L_LOAD || l_q.rd) begin
              // A late answer sends all ones rather than stale data.
              l_d.sh     = l_ack_ok ? s_q.rdata : 8'hff;
              l_d.sda_oe = ~l_d.sh[7];
              l_d.bitc   = 3'h0;
              l_d.st     = L_TX;
            end else begin
              l_d.sda_oe = 1'b0;
              l_d.bitc   = 3'h0;
              l_d.kind   = (l_q.kind == 2'h0) ? 2'h1 : 2'h2;
              l_d.st     = L_RX;
            end
          end
        end
        L_TX: begin
          if (l_rise) begin
            l_d.bitc = l_q.bitc + 3'h1;
            if (l_q.bitc == 3'h7) begin
              l_d.st = L_TXA1;
            end
          end else if (l_fall) begin
            l_d.sh     = {l_q.sh[6:0], 1'b0};
            l_d.sda_oe = ~l_q.sh[6];
          end
        end
        L_TXA1: begin
          if (l_fall) begin
            l_d.sda_oe = 1'b0;
            l_d.st     = L_TXA2;
          end
        end
        L_TXA2: begin
          if (l_rise) begin
            l_d.ptr = l_nxt;
            if (!l_q.sda_s2) begin
              l_d.req_tgl = ~l_q.req_tgl;
              l_d.req     = '{wr: 1'b0, addr: l_nxt, data: 8'h00};
              l_d.st      = L_LOAD;
            end else begin
              l_d.st = L_IDLE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      // Pins idle high, so the samplers start high to avoid a false edge.
      l_q <= '{scl_s1: 1'b1, scl_s2: 1'b1, scl_s3: 1'b1, sda_s1: 1'b1,
               sda_s2: 1'b1, sda_s3: 1'b1, st: L_IDLE, default: '0};
    end else begin
      l_q <= l_d;
    end
  end

  assign sda_o      = 1'b0;
  assign sda_oe     = l_q.sda_oe;
  assign reset_n_o  = 1'b0;
  assign reset_oe   = s_q.rst_oe;
  assign osc_enable = s_q.osc_en;
  assign standby    = s_q.standby;
  assign charge     = s_q.chg;

  sequence hold_seq;
    s_q.rst_oe [*8];
  endsequence

  reset_on_fail_a: assert property (
    @(posedge clk) disable iff (rst) !s_q.vok_s2 |=> s_q.rst_oe)
    else $error("reset not driven on supply fail");

  release_hold_a: assert property (
    @(posedge clk) disable iff (rst)
    (s_q.pf == PF_DOWN && s_q.vok_s2) |=> hold_seq)
    else $error("reset released too early");

  extend_hold_a: assert property (
    @(posedge clk) disable iff (rst)
    (s_q.pf == PF_HOLD && s_q.hold > 32'(RELEASE_CYC)) |-> s_q.was_off)
    else $error("hold extended without oscillator stop");

  access_block_a: assert property (
    @(posedge clk) disable iff (rst)
    !s_q.vok_s2 |=> $stable(s_q.trickle) && $stable(s_q.ctrl_dis))
    else $error("register changed while supply low");

  osc_main_a: assert property (
    @(posedge clk) disable iff (rst) !$past(s_q.bk_s2) |-> s_q.osc_en)
    else $error("oscillator stopped on main power");

  osc_halt_a: assert property (
    @(posedge clk) disable iff (rst)
    (s_q.bk_s2 && s_q.ctrl_dis) |=> !s_q.osc_en && s_q.standby)
    else $error("oscillator not halted on backup");

  count_hold_a: assert property (
    @(posedge clk) disable iff (rst)
    (s_q.ctrl_dis && !s_cnt_wr) |=> $stable(s_q.count))
    else $error("counter advanced while disabled");

  key_gate_a: assert property (
    @(posedge clk) disable iff (rst)
    (s_q.trickle[KEY_LSB +: 4] != CHARGE_KEY) |=> !s_q.chg.en)
    else $error("charger on without key");

  field_gate_a: assert property (
    @(posedge clk) disable iff (rst)
    s_q.chg.en |-> $past(s_q.trickle[RES_LSB +: 2]) != RES_OFF)
    else $error("charger on with resistor off");

  link_refuse_a: assert property (
    @(posedge link_clk) disable iff (rst)
    !l_q.vok_s2 |=> !l_q.sda_oe ##1 !l_q.sda_oe)
    else $error("slave drove bus while supply low");

  start_seen_a: assert property (
    @(posedge link_clk) disable iff (rst)
    (l_start && l_q.vok_s2) |=> l_q.st == L_RX && l_q.bitc == 3'h0)
    else $error("start not recognised");

endmodule : scrc_top

// *** bench/scrc_master.sv ***
// Purpose: Two-wire bus master model that drives the serial slave.
// Assumes: The bench resolves SDA from all enables with a pull-up.
// Notes: Lines change just after a rising clk edge; q sets the rate.
module scrc_master (
  input  wire logic clk,
  input  wire logic sda,
  output      logic scl,
  output      logic sda_m
);
  timeunit 1ns;
  timeprecision 1ns;

  // Quarter bit in clk cycles: 7 runs near 357 kHz, 25 at 100 kHz.
  int q = 7;

  initial begin
    scl   = 1'b1;
    sda_m = 1'b1;
  end

  task automatic step(input logic c, input logic d);
    @(posedge clk);
    scl   <= c;
    sda_m <= d;
    repeat (q - 1) @(posedge clk);
  endtask : step

  // Data moves only with SCL low, so no false condition is ever seen.
  task automatic bit_io(input logic d, output logic s);
    step(1'b0, d);
    step(1'b1, d);
    s = sda;
    step(1'b1, d);
    step(1'b0, d);
  endtask : bit_io

  task automatic start();
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
  endtask : start

  task automatic stop();
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
  endtask : stop

  task automatic wr(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
    end
    bit_io(1'b1, s);
    ack = ~s;
  endtask : wr

  task automatic rd(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      b[i] = s;
    end
    bit_io(last, s);
  endtask : rd

endmodule : scrc_master

// *** bench/seconds_counter_rtc_power_ctrl_test.sv ***
// Purpose: Self-checking bench for the seconds counter with power control.
// Assumes: Short reset holds; SDA and reset wires have pull-ups.
// Notes: A counter tick takes 65536 clk cycles, so only one is awaited.
module seconds_counter_rtc_power_ctrl_test;
  timeunit 1ns;
  timeprecision 1ns;
  import scrc_pkg::*;

  localparam int REL = 50;
  localparam int STU = 30;

  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       link_clk = 1'b0;
  logic       vcc_ok = 1'b1;
  logic       on_backup = 1'b0;
  logic       osc = 1'b0;
  logic       scl;
  logic       sda_m;
  wire logic  sda;
  logic       sda_o;
  logic       sda_oe;
  logic       reset_n_o;
  logic       reset_oe;
  wire logic  reset_n;
  logic       osc_enable;
  logic       standby;
  scrc_chg_s  charge;
  logic       ok;
  logic [7:0] rb[8];
  int         error_cnt = 0;
  int         comparisons = 0;

  // Released open-drain wires float up to their pull-ups.
  assign sda     = sda_m & (sda_oe ? sda_o : 1'b1);
  assign reset_n = reset_oe ? reset_n_o : 1'b1;

  always #50 clk = ~clk;

  initial begin
    #3;
    forever #6 link_clk = ~link_clk;
  end

  // The oscillator stands still while the device has stopped it.
  always @(posedge clk) begin
    if (osc_enable) begin
      osc <= ~osc;
    end
  end

  scrc_master m (.clk(clk), .sda(sda), .scl(scl), .sda_m(sda_m));

  scrc_top #(.RELEASE_CYC(REL), .STARTUP_CYC(STU)) DUT (
    .clk        (clk),
    .rst        (rst),
    .link_clk   (link_clk),
    .vcc_ok     (vcc_ok),
    .on_backup  (on_backup),
    .osc_in     (osc),
    .scl_i      (scl),
    .sda_i      (sda),
    .sda_o      (sda_o),
    .sda_oe     (sda_oe),
    .reset_n_i  (reset_n),
    .reset_n_o  (reset_n_o),
    .reset_oe   (reset_oe),
    .osc_enable (osc_enable),
    .standby    (standby),
    .charge     (charge)
  );

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic conclude();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude

  task automatic ptr(input logic [2:0] p);
    logic a;
    m.start();
    m.wr({SLAVE_ADDR, 1'b0}, ok);
    m.wr({5'h0, p}, a);
    ok = ok & a;
  endtask : ptr

  task automatic wregs(input logic [2:0] p, input logic [7:0] d[$]);
    logic a;
    ptr(p);
    foreach (d[i]) begin
      m.wr(d[i], a);
      ok = ok & a;
    end
    m.stop();
  endtask : wregs

  // Reads from the pointer with a repeated start; the last byte is refused.
  task automatic rregs(input int n);
    logic a;
    m.start();
    m.wr({SLAVE_ADDR, 1'b1}, a);
    ok = ok & a;
    for (int i = 0; i < n; i++) begin
      m.rd(i == n - 1, rb[i]);
    end
    m.stop();
  endtask : rregs

  task automatic hold(input int exp);
    int n;
    n = 0;
    while (reset_oe !== 1'b0 && n < exp + 20) begin
      @(negedge clk);
      n++;
    end
    chk(8'(n >= exp && n <= exp + 8), 8'h1);
  endtask : hold

  task automatic t_reset();
    hold(REL);
    chk(8'({osc_enable, standby, charge}), 8'h20);
    ptr(REG_CTRL);
    rregs(2);
    chk(rb[0], 8'h00);
    chk(rb[1], TRICKLE_RST);
    chk(8'(ok), 8'h1);
  endtask : t_reset

  task automatic t_trickle();
    logic [7:0] v[10] = '{8'ha5, 8'haa, 8'ha7, 8'ha9, 8'hab, 8'ha1,
                          8'had, 8'ha4, 8'h55, 8'hb6};
    logic       en;
    logic [2:0] e;
    foreach (v[i]) begin
      m.q = (i == 0) ? 25 : 7;
      wregs(REG_TRICKLE, '{v[i]});
      en = v[i][7:4] == CHARGE_KEY && v[i][1:0] != RES_OFF &&
           (v[i][3:2] == DIODE_NONE || v[i][3:2] == DIODE_ONE);
      e = {en, en ? v[i][1:0] : RES_OFF};
      @(negedge clk);
      chk(8'({charge.en, charge.res}), 8'(e));
      if (en) begin
        chk(8'(charge.diode), 8'(v[i][3:2] == DIODE_ONE));
      end
      if (i < 3) begin
        ptr(REG_TRICKLE);
        rregs(1);
        chk(rb[0], v[i]);
        chk(8'(ok), 8'h1);
      end
    end
    m.q = 7;
  endtask : t_trickle

  task automatic t_map();
    wregs(REG_CTRL, '{8'hff, 8'h00, 8'h11, 8'h22, 8'h33});
    chk(8'(ok), 8'h1);
    @(negedge clk);
    chk(8'({osc_enable, standby}), 8'h2);
    ptr(REG_CTRL);
    rregs(5);
    chk(rb[0], 8'h80);
    chk(rb[1], 8'h00);
    chk(rb[2], 8'h11);
    chk(rb[3], 8'h22);
    chk(rb[4], 8'h33);
    ok = 1'b1;
    rregs(2);
    chk(rb[0], 8'h00);
    chk(rb[1], 8'h80);
    m.q = 25;
    m.start();
    m.wr({SLAVE_ADDR ^ 7'h01, 1'b0}, ok);
    m.stop();
    chk(8'(ok), 8'h0);
    ptr(3'h7);
    rregs(1);
    chk(rb[0], 8'h11);
    m.q = 7;
  endtask : t_map

  task automatic t_power();
    wregs(REG_CTRL, '{8'h00, 8'ha5});
    @(posedge clk);
    vcc_ok <= 1'b0;
    repeat (5) @(negedge clk);
    chk(8'(reset_oe), 8'h1);
    chk(8'(reset_n), 8'h0);
    wregs(REG_TRICKLE, '{8'h00});
    chk(8'(ok), 8'h0);
    @(posedge clk);
    on_backup <= 1'b1;
    repeat (5) @(negedge clk);
    chk(8'({osc_enable, standby}), 8'h2);
    @(posedge clk);
    on_backup <= 1'b0;
    vcc_ok    <= 1'b1;
    hold(REL);
    ptr(REG_TRICKLE);
    rregs(1);
    chk(rb[0], 8'ha5);
    wregs(REG_CTRL, '{8'h80});
    @(posedge clk);
    vcc_ok    <= 1'b0;
    on_backup <= 1'b1;
    repeat (5) @(negedge clk);
    chk(8'({osc_enable, standby}), 8'h1);
    @(posedge clk);
    on_backup <= 1'b0;
    vcc_ok    <= 1'b1;
    hold(REL + STU);
    chk(8'(osc_enable), 8'h1);
  endtask : t_power

  // Byte 0 goes last, after counting resumes, so no carry is lost.
  task automatic t_count();
    logic [31:0] c;
    wregs(3'h1, '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff});
    repeat (66000) @(posedge clk);
    ptr(REG_CNT0);
    rregs(4);
    c = {rb[3], rb[2], rb[1], rb[0]};
    chk(8'(c == 32'h100 || c == 32'h101), 8'h1);
  endtask : t_count

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_trickle();
    t_map();
    t_power();
    t_count();
    conclude();
  end

  initial begin
    repeat (115000) @(posedge clk);
    error_cnt++;
    $display("[ERR] %0t watchdog expired", $time);
    conclude();
  end

endmodule : seconds_counter_rtc_power_ctrl_test
